// ### logic/touch_pkg.sv
// Constants and types shared by the touch register bank
package touch_pkg;

  // ==========================================================
  // Sizes
  localparam int NUM_PADS = 8;

  // ==========================================================
  // Command opcodes
  localparam logic [7:0] OP_SOFT_RESET  = 8'h00;
  localparam logic [7:0] OP_CLEAR_ALERT = 8'h03;
  localparam logic [7:0] OP_WR_SETUP    = 8'h30;
  localparam logic [7:0] OP_RD_SETUP    = 8'h33;
  localparam logic [7:0] OP_WR_TICK     = 8'h35;
  localparam logic [7:0] OP_RD_TICK     = 8'h36;
  localparam logic [7:0] OP_WR_GATE     = 8'h39;
  localparam logic [7:0] OP_RD_GATE     = 8'h3A;

  // ==========================================================
  // Values after reset and the tick write mask
  localparam logic [7:0] SETUP_RST = 8'h00;
  localparam logic [7:0] STATE_RST = 8'h00;
  localparam logic [7:0] TICK_RST  = 8'h0C;
  localparam logic [7:0] GATE_RST  = 8'hFF;
  localparam logic [7:0] TICK_WMASK = 8'hDF;
  localparam logic [7:0] ZERO_BYTE = 8'h00;

  // ==========================================================
  // Setup register fields
  localparam int ROLE_HI       = 7;
  localparam int ROLE_LO       = 6;
  localparam int SWITCH_BIT    = 5;
  localparam int KEY_HI        = 4;
  localparam int KEY_LO        = 3;
  localparam int REG_OFF_BIT   = 2;
  localparam int ALERT_POL_BIT = 1;
  localparam int MPWR_BIT      = 0;

  // ==========================================================
  // Tick setting register fields
  localparam int EXPORT_BIT = 7;
  localparam int IMPORT_BIT = 6;
  localparam int COARSE_HI  = 4;
  localparam int COARSE_LO  = 3;
  localparam int TRIM_HI    = 2;
  localparam int TRIM_LO    = 0;

  // ==========================================================
  // Field decodes
  typedef enum logic [1:0] {
    ROLE_ALONE,
    ROLE_SECONDARY,
    ROLE_PRIMARY,
    ROLE_UNUSED
  } role_t;

  typedef enum logic [1:0] {
    KEY_ALL,
    KEY_TWO,
    KEY_ONE,
    KEY_UNUSED
  } key_t;

endpackage

// ### logic/bit_sync.sv
// Two flip-flop synchroniser for a group of level signals
`timescale 1ns/1ps
module bit_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_in,
  input  wire logic [WIDTH-1:0] d_in,
  output logic      [WIDTH-1:0] q_out
);
  // ==========================================================
  // Stages
  // First stage feeds only the second one
  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] hold_r;

  always_ff @(posedge clk_in) begin
    meta_r <= d_in;
    hold_r <= meta_r;
  end

  assign q_out = hold_r;
endmodule

// ### logic/touch_regs.sv
// Setup, touch state, tick and gate registers of the touch sensor
`timescale 1ns/1ps
module touch_regs
  import touch_pkg::*;
#(
  parameter int PADS = NUM_PADS
) (
  input  wire logic            clk_in,
  input  wire logic            rst_n_in,
  input  wire logic            link_clk_in,
  input  wire logic            link_req_in,
  input  wire logic            link_sense_rd_in,
  input  wire logic [7:0]      link_op_in,
  input  wire logic [7:0]      link_wdata_in,
  output logic                 link_busy_out,
  output logic                 link_done_out,
  output logic      [7:0]      link_rdata_out,
  input  wire logic [PADS-1:0] pad_active_in,
  output logic                 alert_n_out,
  output logic                 tick_export_en_out,
  output logic                 tick_import_en_out,
  output logic                 osc_run_out,
  output logic                 regulator_off_out,
  output logic      [PADS-1:0] pad_power_down_out,
  output logic      [1:0]      coarse_divider_out,
  output logic      [2:0]      oscillator_trim_out
);

  // ==========================================================
  // Link domain: command capture and reply
  logic       link_rst_n;
  logic       ack_s;
  logic       req_tog_r;
  logic       busy_r;
  logic       ack_seen_r;
  logic       done_r;
  logic       sense_rd_r;
  logic [7:0] op_r;
  logic [7:0] wdata_r;
  logic [7:0] rdata_r;
  logic [7:0] reply_r;
  logic       ack_tog_r;
  logic       ack_edge;
  logic       take_req;

  bit_sync #(.WIDTH(1)) u_lrst (
    .clk_in (link_clk_in),
    .d_in   (rst_n_in),
    .q_out  (link_rst_n)
  );

  bit_sync #(.WIDTH(1)) u_ack (
    .clk_in (link_clk_in),
    .d_in   (ack_tog_r),
    .q_out  (ack_s)
  );

  assign ack_edge = ack_s ^ ack_seen_r;
  assign take_req = link_req_in && !busy_r;

  // Operands stay still until the answer returns, so the core
  // may sample them after the toggle has crossed
  always_ff @(posedge link_clk_in) begin
    if (!link_rst_n) begin
      req_tog_r  <= 1'b0;
      busy_r     <= 1'b0;
      sense_rd_r <= 1'b0;
      op_r       <= ZERO_BYTE;
      wdata_r    <= ZERO_BYTE;
    end else if (take_req) begin
      req_tog_r  <= ~req_tog_r;
      busy_r     <= 1'b1;
      sense_rd_r <= link_sense_rd_in;
      op_r       <= link_op_in;
      wdata_r    <= link_wdata_in;
    end else if (ack_edge) begin
      busy_r     <= 1'b0;
    end
  end

  always_ff @(posedge link_clk_in) begin
    if (!link_rst_n) begin
      ack_seen_r <= 1'b0;
      done_r     <= 1'b0;
      rdata_r    <= ZERO_BYTE;
    end else begin
      ack_seen_r <= ack_s;
      done_r     <= ack_edge;
      if (ack_edge) begin
        rdata_r <= reply_r;
      end
    end
  end

  assign link_busy_out  = busy_r;
  assign link_done_out  = done_r;
  assign link_rdata_out = rdata_r;

  // ==========================================================
  // Core domain: request detection
  logic            req_s;
  logic            req_seen_r;
  logic            go;
  logic [PADS-1:0] act_s;

  bit_sync #(.WIDTH(1)) u_req (
    .clk_in (clk_in),
    .d_in   (req_tog_r),
    .q_out  (req_s)
  );

  bit_sync #(.WIDTH(PADS)) u_pad (
    .clk_in (clk_in),
    .d_in   (pad_active_in),
    .q_out  (act_s)
  );

  assign go = req_s ^ req_seen_r;

  // ==========================================================
  // Command decode
  logic soft_rst;
  logic clr_cmd;
  logic wr_setup;
  logic wr_tick;
  logic wr_gate;
  logic sense_rd;

  assign sense_rd = go && sense_rd_r;
  assign soft_rst = go && !sense_rd_r && (op_r == OP_SOFT_RESET);
  assign clr_cmd  = go && !sense_rd_r && (op_r == OP_CLEAR_ALERT);
  assign wr_setup = go && !sense_rd_r && (op_r == OP_WR_SETUP);
  assign wr_tick  = go && !sense_rd_r && (op_r == OP_WR_TICK);
  assign wr_gate  = go && !sense_rd_r && (op_r == OP_WR_GATE);

  // ==========================================================
  // Configuration registers
  logic [7:0] setup_r;
  logic [7:0] tick_r;
  logic [7:0] gate_r;

  always_ff @(posedge clk_in) begin
    if (!rst_n_in || soft_rst) begin
      setup_r <= SETUP_RST;
      tick_r  <= TICK_RST;
      gate_r  <= GATE_RST;
    end else begin
      if (wr_setup) begin
        setup_r <= wdata_r;
      end
      if (wr_tick) begin
        tick_r <= wdata_r & TICK_WMASK;
      end
      if (wr_gate) begin
        gate_r <= wdata_r;
      end
    end
  end

  // ==========================================================
  // Field decode and clock source selection
  role_t role;
  key_t  key_pol;
  logic  latch_mode;
  logic  press_only;

  assign role       = role_t'(setup_r[ROLE_HI:ROLE_LO]);
  assign key_pol    = key_t'(setup_r[KEY_HI:KEY_LO]);
  assign latch_mode = setup_r[SWITCH_BIT];
  assign press_only = setup_r[ALERT_POL_BIT];

  // Unused role code behaves as stand-alone
  assign tick_export_en_out = (role == ROLE_PRIMARY)
                            || tick_r[EXPORT_BIT];
  assign tick_import_en_out = (role == ROLE_SECONDARY)
                            || tick_r[IMPORT_BIT];
  assign osc_run_out        = !tick_import_en_out;
  assign regulator_off_out  = setup_r[REG_OFF_BIT];
  assign pad_power_down_out = setup_r[MPWR_BIT] ? ~gate_r
                                                : '0;
  assign coarse_divider_out  = tick_r[COARSE_HI:COARSE_LO];
  assign oscillator_trim_out = tick_r[TRIM_HI:TRIM_LO];

  // ==========================================================
  // Touch state update
  logic [PADS-1:0] state_r;
  logic [PADS-1:0] state_nxt;
  logic [PADS-1:0] live;
  logic [PADS-1:0] kept;
  logic [PADS-1:0] fresh;
  logic [PADS-1:0] admitted;
  logic [3:0]      held_cnt;
  logic [3:0]      room;
  logic [3:0]      limit;

  // Gated-off pads never report activity
  assign live = act_s & gate_r;

  // Direct drops released pads at once; latching only on a read
  assign kept = (!latch_mode || sense_rd) ? (state_r & live)
                                          : state_r;
  assign fresh    = live & ~kept;
  assign held_cnt = 4'($countones(kept));
  assign limit    = (key_pol == KEY_ONE) ? 4'h1 :
                    (key_pol == KEY_TWO) ? 4'h2 : 4'($unsigned(PADS));
  assign room     = (held_cnt >= limit) ? 4'h0 : 4'(limit - held_cnt);

  // Lower pad index wins when presses arrive together
  always_comb begin
    logic [3:0] used;
    used     = 4'h0;
    admitted = '0;
    for (int i = 0; i < PADS; i++) begin
      if (fresh[i] && (used < room)) begin
        admitted[i] = 1'b1;
        used        = 4'(used + 4'h1);
      end
    end
  end

  assign state_nxt = kept | admitted;

  always_ff @(posedge clk_in) begin
    if (!rst_n_in || soft_rst) begin
      state_r <= STATE_RST;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ==========================================================
  // Alert
  logic [PADS-1:0] rose;
  logic [PADS-1:0] fell;
  logic            change;
  logic            pair_ok;
  logic            event_hit;
  logic            alert_r;
  logic            alert_nxt;

  assign rose      = state_nxt & ~state_r;
  assign fell      = state_r & ~state_nxt;
  assign change    = press_only ? (|rose) : (|(rose | fell));
  assign pair_ok   = (key_pol != KEY_TWO)
                   || ($countones(state_nxt) >= 2);
  assign event_hit = change && pair_ok;
  // A new event in the clearing cycle keeps the alert raised
  assign alert_nxt = event_hit
                   || (alert_r && !(sense_rd || clr_cmd));

  always_ff @(posedge clk_in) begin
    if (!rst_n_in || soft_rst) begin
      alert_r <= 1'b0;
    end else begin
      alert_r <= alert_nxt;
    end
  end

  assign alert_n_out = !alert_r;

  // ==========================================================
  // Reply and acknowledge
  logic [7:0] reply_nxt;

  assign reply_nxt = sense_rd                 ? state_r :
                     (op_r == OP_RD_SETUP)    ? setup_r :
                     (op_r == OP_RD_TICK)     ? tick_r  :
                     (op_r == OP_RD_GATE)     ? gate_r  : ZERO_BYTE;

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      req_seen_r <= 1'b0;
      ack_tog_r  <= 1'b0;
      reply_r    <= ZERO_BYTE;
    end else if (go) begin
      req_seen_r <= req_s;
      ack_tog_r  <= ~ack_tog_r;
      reply_r    <= reply_nxt;
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  sequence quiet_s;
    !go;
  endsequence

  sequence read_s;
    go && sense_rd_r;
  endsequence

  role_secondary_a : assert property (
    (role == ROLE_SECONDARY) |->
      (tick_import_en_out && !osc_run_out && !tick_export_en_out
       || tick_r[EXPORT_BIT]))
    else $error("secondary role clock pins wrong");

  role_primary_a : assert property (
    (role == ROLE_PRIMARY && !tick_r[IMPORT_BIT]) |->
      (tick_export_en_out && osc_run_out && !tick_import_en_out))
    else $error("primary role clock pins wrong");

  reset_defaults_a : assert property (
    $rose(rst_n_in) |->
      (setup_r == SETUP_RST && tick_r == TICK_RST
       && gate_r == GATE_RST && state_r == STATE_RST
       && !tick_export_en_out && !tick_import_en_out && osc_run_out))
    else $error("reset values wrong");

  direct_release_a : assert property (
    (!latch_mode && !go) ##1 quiet_s |->
      ((state_r & ~$past(live)) == '0))
    else $error("direct mode kept a released bit");

  latch_hold_a : assert property (
    (latch_mode && !go) |=>
      ((state_r & $past(state_r)) == $past(state_r)))
    else $error("latching mode lost a bit without a read");

  latch_clear_a : assert property (
    (latch_mode && sense_rd) |=>
      ((state_r & ~$past(live)) == '0))
    else $error("read left an inactive latched bit");

  one_key_a : assert property (
    (key_pol == KEY_ONE && $countones(state_r) <= 1) ##1 quiet_s |->
      ($countones(state_r) <= 1))
    else $error("one-key policy let two bits in");

  read_value_a : assert property (
    read_s |=> (reply_r == $past(state_r)) ##1 (reply_r == $past(reply_r)))
    else $error("state read returned cleared value");

  alert_clear_a : assert property (
    ((clr_cmd || sense_rd) && !event_hit) |=> alert_n_out)
    else $error("alert not dropped by clear or read");

  two_key_a : assert property (
    (key_pol == KEY_TWO && !alert_r && $countones(state_nxt) < 2) |=>
      alert_n_out)
    else $error("two-key alert raised early");

endmodule

// ### test/link_ctrl_model.sv
// Controller model that issues link commands to the register bank
`timescale 1ns/1ps
module link_ctrl_model (
  input  wire logic       hold_run_in,
  input  wire logic       busy_in,
  input  wire logic       done_in,
  input  wire logic [7:0] rdata_in,
  output logic            link_clk_out,
  output logic            req_out,
  output logic            sense_rd_out,
  output logic      [7:0] op_out,
  output logic      [7:0] wdata_out
);
  logic run;

  initial begin
    link_clk_out = 1'b0;
    run = 1'b0;
    req_out = 1'b0;
    sense_rd_out = 1'b0;
    op_out = 8'h00;
    wdata_out = 8'h00;
  end

  // ==========================================
  // Link clock, idle low between commands
  always begin
    #15;
    link_clk_out = (run || hold_run_in) ? ~link_clk_out : 1'b0;
  end

  // ==========================================
  // One command; released lines show inverted data so stale values fail
  task automatic cmd(input logic s, input logic [7:0] op,
                     input logic [7:0] wd, output logic [7:0] rd,
                     output logic ok);
    logic bad;
    logic fin;
    ok = 1'b0;
    bad = 1'b0;
    fin = 1'b0;
    rd = 8'h00;
    run = 1'b1;
    repeat (2) @(posedge link_clk_out);
    req_out <= 1'b1;
    sense_rd_out <= s;
    op_out <= op;
    wdata_out <= wd;
    @(posedge link_clk_out);
    req_out <= 1'b0;
    sense_rd_out <= ~s;
    op_out <= ~op;
    wdata_out <= ~wd;
    // Busy must stand from the take until the done pulse, then drop
    for (int i = 0; i < 40 && !fin; i++) begin
      @(posedge link_clk_out);
      if (done_in === 1'b1) begin
        fin = 1'b1;
        rd = rdata_in;
        bad = bad || (busy_in !== 1'b0);
      end else if (busy_in !== 1'b1) begin
        bad = 1'b1;
      end
    end
    ok = fin && !bad;
    @(negedge link_clk_out);
    run = 1'b0;
  endtask
endmodule

// ### test/touch_regs_tb_top.sv
// Self-checking bench for the touch register bank
`timescale 1ns/1ps
module touch_regs_tb_top;
  import touch_pkg::*;
  logic       clk_in, rst_n_in, hold_run, link_clk, req, sense;
  logic       busy, done, alert_n, exp_en, imp_en, osc_run, reg_off;
  logic [7:0] op, wdata, rdata, pad, pd, rd_v;
  logic [1:0] coarse;
  logic [2:0] trim;
  logic       ok_v;
  int         fails, comparisons;
  logic [7:0] vals [5] = '{8'h80, 8'h40, 8'hC0, 8'h04, 8'h01};

  always #20 clk_in = ~clk_in;

  link_ctrl_model ctrl (.hold_run_in(hold_run), .busy_in(busy),
    .done_in(done), .rdata_in(rdata), .link_clk_out(link_clk),
    .req_out(req), .sense_rd_out(sense), .op_out(op),
    .wdata_out(wdata));

  touch_regs dut (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .link_clk_in(link_clk), .link_req_in(req),
    .link_sense_rd_in(sense), .link_op_in(op), .link_wdata_in(wdata),
    .link_busy_out(busy), .link_done_out(done),
    .link_rdata_out(rdata), .pad_active_in(pad),
    .alert_n_out(alert_n), .tick_export_en_out(exp_en),
    .tick_import_en_out(imp_en), .osc_run_out(osc_run),
    .regulator_off_out(reg_off), .pad_power_down_out(pd),
    .coarse_divider_out(coarse), .oscillator_trim_out(trim));

  // ==========================================
  // Shared tasks
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test();
    if (fails == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic cmd(input logic s, input logic [7:0] o,
                     input logic [7:0] wd);
    ctrl.cmd(s, o, wd, rd_v, ok_v);
    chk({7'h00, ok_v}, 8'h01);
    if (ok_v !== 1'b1) begin
      end_of_test();
    end
  endtask

  task automatic rd(input logic s, input logic [7:0] o,
                    input logic [7:0] exp);
    cmd(s, o, 8'h00);
    chk(rd_v, exp);
  endtask

  // Pads settle through two sync stages, so allow six core cycles
  task automatic press(input logic [7:0] v);
    @(posedge clk_in);
    pad <= v;
    repeat (6) @(posedge clk_in);
    #1;
  endtask

  // ==========================================
  // Main sequence
  initial begin
    clk_in = 1'b0;
    rst_n_in = 1'b0;
    hold_run = 1'b1;
    pad = 8'h00;
    fails = 0;
    comparisons = 0;
    repeat (16) @(posedge clk_in);
    rst_n_in <= 1'b1;
    repeat (4) @(posedge clk_in);
    hold_run <= 1'b0;
    rd(1'b0, OP_RD_SETUP, 8'h00);
    cmd(1'b0, OP_RD_TICK, 8'h00);
    chk(rd_v & 8'hDF, 8'h0C);
    rd(1'b0, OP_RD_GATE, 8'hFF);
    rd(1'b1, 8'h00, 8'h00);
    chk({7'h00, alert_n}, 8'h01);
    chk({6'h00, exp_en, imp_en}, 8'h00);
    chk({7'h00, osc_run}, 8'h01);
    cmd(1'b0, OP_WR_GATE, 8'h0F);
    foreach (vals[i]) begin
      cmd(1'b0, OP_WR_SETUP, vals[i]);
      rd(1'b0, OP_RD_SETUP, vals[i]);
      chk({7'h00, exp_en}, {7'h00, vals[i][7:6] == 2'b10});
      chk({7'h00, imp_en}, {7'h00, vals[i][7:6] == 2'b01});
      chk({7'h00, osc_run}, {7'h00, vals[i][7:6] != 2'b01});
      chk({7'h00, reg_off}, {7'h00, vals[i][2]});
      chk(pd, vals[i][0] ? 8'hF0 : 8'h00);
    end
    cmd(1'b0, OP_WR_SETUP, 8'h00);
    cmd(1'b0, OP_WR_GATE, 8'hFF);
    // Direct behaviour, alert on every change
    press(8'h05);
    chk({7'h00, alert_n}, 8'h00);
    rd(1'b1, 8'h00, 8'h05);
    chk({7'h00, alert_n}, 8'h01);
    press(8'h01);
    chk({7'h00, alert_n}, 8'h00);
    rd(1'b1, 8'h00, 8'h01);
    press(8'h00);
    cmd(1'b0, OP_CLEAR_ALERT, 8'h00);
    chk({7'h00, alert_n}, 8'h01);
    rd(1'b1, 8'h00, 8'h00);
    // Press-only alerts
    cmd(1'b0, OP_WR_SETUP, 8'h02);
    press(8'h01);
    rd(1'b1, 8'h00, 8'h01);
    press(8'h00);
    chk({7'h00, alert_n}, 8'h01);
    // Latching behaviour
    cmd(1'b0, OP_WR_SETUP, 8'h20);
    press(8'h81);
    press(8'h00);
    rd(1'b1, 8'h00, 8'h81);
    rd(1'b1, 8'h00, 8'h00);
    press(8'h02);
    rd(1'b1, 8'h00, 8'h02);
    rd(1'b1, 8'h00, 8'h02);
    press(8'h00);
    rd(1'b1, 8'h00, 8'h02);
    rd(1'b1, 8'h00, 8'h00);
    // Key policies
    cmd(1'b0, OP_WR_SETUP, 8'h10);
    press(8'h01);
    press(8'h03);
    rd(1'b1, 8'h00, 8'h01);
    press(8'h00);
    cmd(1'b0, OP_WR_SETUP, 8'h08);
    cmd(1'b0, OP_CLEAR_ALERT, 8'h00);
    press(8'h01);
    chk({7'h00, alert_n}, 8'h01);
    press(8'h07);
    chk({7'h00, alert_n}, 8'h00);
    rd(1'b1, 8'h00, 8'h03);
    press(8'h00);
    // Unused key code admits every pad; unknown opcode replies zero
    cmd(1'b0, OP_WR_SETUP, 8'h18);
    press(8'h0F);
    rd(1'b1, 8'h00, 8'h0F);
    press(8'h00);
    rd(1'b0, 8'h05, 8'h00);
    // Tick register and soft reset
    cmd(1'b0, OP_WR_TICK, 8'hDF);
    cmd(1'b0, OP_RD_TICK, 8'h00);
    chk(rd_v & 8'hDF, 8'hDF);
    chk({6'h00, exp_en, imp_en}, 8'h03);
    chk({3'h0, coarse, trim}, 8'h1F);
    cmd(1'b0, OP_WR_SETUP, 8'h20);
    cmd(1'b0, OP_SOFT_RESET, 8'h00);
    rd(1'b0, OP_RD_SETUP, 8'h00);
    rd(1'b0, OP_RD_GATE, 8'hFF);
    chk({6'h00, exp_en, imp_en}, 8'h00);
    press(8'h01);
    press(8'h00);
    rd(1'b1, 8'h00, 8'h00);
    end_of_test();
  end
endmodule
